/* pkg/alu_pkg.sv */
package alu_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int IMM_W = 6;
  localparam int IOA_W = 6;
  // io space reachable by the single-bit set and clear instructions
  localparam logic [5:0] IO_BIT_LO = 6'h00;
  localparam logic [5:0] IO_BIT_HI = 6'h1f;
  // cycle counts per instruction class
  localparam int CYC_BYTE = 1;
  localparam int CYC_WORD = 2;
  // status flag positions in the flag vector
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_W = 6;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  typedef enum logic [3:0] {
    ALU_ADD  = 4'h0,
    ALU_ADC  = 4'h1,
    ALU_SUB  = 4'h2,
    ALU_SUBB  = 4'h3,
    ALU_SUBK  = 4'h4,
    ALU_SUBBK = 4'h5,
    ALU_AND  = 4'h6,
    ALU_ANDK  = 4'h7,
    ALU_OR   = 4'h8,
    ALU_WADD = 4'h9,
    ALU_WSUB = 4'ha,
    ALU_BSET = 4'hb,
    ALU_BCLR = 4'hc
  } alu_op_e;
  typedef enum logic [1:0] {
    ALU_IDLE  = 2'b00,
    ALU_WORD2 = 2'b01
  } alu_st_e;
endpackage : alu_pkg

/* hdl/alu_byte_core.sv */
`timescale 1ns/100ps
// 8-bit add/subtract/logic slice with flag generation
module alu_byte_core (
  // operands
  input wire logic [alu_pkg::DATA_W-1:0] a,
  input wire logic [alu_pkg::DATA_W-1:0] b,
  input wire logic cin,
  input wire logic sub,
  input wire logic [1:0] fn,
  // result
  output logic [alu_pkg::DATA_W-1:0] y,
  output logic cout,
  output logic half,
  output logic ovf,
  output logic zero,
  output logic neg
);
  import alu_pkg::*;
  logic [DATA_W:0] sum;
  logic [4:0] lo;
  logic [DATA_W-1:0] bx;
  always_comb begin
    bx = sub ? ~b : b;
    sum = {1'b0, a} + {1'b0, bx} + {{DATA_W{1'b0}}, (sub ^ cin)};
    lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, (sub ^ cin)};
    y = sum[DATA_W-1:0];
    cout = sum[DATA_W] ^ sub;
    half = lo[4] ^ sub;
    ovf = (a[DATA_W-1] == bx[DATA_W-1]) && (y[DATA_W-1] != a[DATA_W-1]);
    if (fn == 2'd1) begin
      y = a & b;
      ovf = 1'b0;
    end else if (fn == 2'd2) begin
      y = a | b;
      ovf = 1'b0;
    end
    zero = (y == '0);
    neg = y[DATA_W-1];
  end
endmodule : alu_byte_core

/* hdl/alu_exec.sv */
`timescale 1ns/100ps
module alu_exec (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction from decoder
  input wire logic op_valid,
  input wire alu_pkg::alu_op_e op,
  input wire logic [alu_pkg::DATA_W-1:0] dst_val,
  input wire logic [alu_pkg::DATA_W-1:0] src_val,
  input wire logic [alu_pkg::DATA_W-1:0] dst_hi_val,
  input wire logic [alu_pkg::DATA_W-1:0] imm,
  input wire logic [alu_pkg::IOA_W-1:0] io_addr,
  input wire logic [2:0] io_bit,
  input wire logic [alu_pkg::DATA_W-1:0] io_rd_data,
  input wire logic [alu_pkg::DATA_W-1:0] io_w1c_mask,
  // results
  output logic busy,
  output logic res_valid,
  output logic res_hi_valid,
  output logic [alu_pkg::DATA_W-1:0] res,
  output logic [alu_pkg::DATA_W-1:0] res_hi,
  output logic io_we,
  output logic io_refused,
  output logic [alu_pkg::IOA_W-1:0] io_wr_addr,
  output logic [alu_pkg::DATA_W-1:0] io_wr_data,
  output logic [alu_pkg::FLG_W-1:0] flags
);
  import alu_pkg::*;
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  function automatic logic is_word(input alu_op_e o);
    return (o == ALU_WADD) || (o == ALU_WSUB);
  endfunction : is_word
  function automatic logic is_io(input alu_op_e o);
    return (o == ALU_BSET) || (o == ALU_BCLR);
  endfunction : is_io

  alu_st_e st_q;
  logic wsub_q, carry_lo_q, zero_lo_q;
  logic [DATA_W-1:0] hi_q, res_lo_q;
  logic take;
  assign take = op_valid && (st_q == ALU_IDLE);
  assign busy = (st_q != ALU_IDLE);

  // operand select for the shared byte slice
  logic [DATA_W-1:0] a, b, y;
  logic cin, sub, co, hc, ov, zr, ng;
  logic [1:0] fn;
  always_comb begin
    a = dst_val;
    b = src_val;
    cin = 1'b0;
    sub = 1'b0;
    fn = 2'd0;
    if (st_q == ALU_WORD2) begin
      // high byte: propagate carry/borrow of the low byte, operand zero
      a = hi_q;
      b = '0;
      cin = carry_lo_q;
      sub = wsub_q;
    end else begin
      unique case (op)
        ALU_ADD: ;
        ALU_ADC: cin = flags[FLG_C];
        ALU_SUB: sub = 1'b1;
        ALU_SUBB: begin
          sub = 1'b1;
          cin = flags[FLG_C];
        end
        ALU_SUBK: begin
          sub = 1'b1;
          b = imm;
        end
        ALU_SUBBK: begin
          sub = 1'b1;
          b = imm;
          cin = flags[FLG_C];
        end
        ALU_AND: fn = 2'd1;
        ALU_ANDK: begin
          fn = 2'd1;
          b = imm;
        end
        ALU_OR: fn = 2'd2;
        ALU_WADD: b = {2'b00, imm[IMM_W-1:0]};
        ALU_WSUB: begin
          sub = 1'b1;
          b = {2'b00, imm[IMM_W-1:0]};
        end
        default: ;
      endcase
    end
  end

  alu_byte_core u_core (
    .a(a),
    .b(b),
    .cin(cin),
    .sub(sub),
    .fn(fn),
    .y(y),
    .cout(co),
    .half(hc),
    .ovf(ov),
    .zero(zr),
    .neg(ng)
  );

  // word sequencing: low byte in cycle one, high byte in cycle two
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ALU_IDLE;
      wsub_q <= 1'b0;
      carry_lo_q <= 1'b0;
      zero_lo_q <= 1'b0;
      hi_q <= '0;
      res_lo_q <= '0;
    end else if (take && is_word(op)) begin
      st_q <= ALU_WORD2;
      wsub_q <= (op == ALU_WSUB);
      carry_lo_q <= co;
      zero_lo_q <= zr;
      hi_q <= dst_hi_val;
      res_lo_q <= y;
    end else begin
      st_q <= ALU_IDLE;
    end
  end

  // io read-modify-write; set flags read back as one get written as one
  logic io_ok;
  logic [DATA_W-1:0] io_mod;
  always_comb begin
    io_ok = (io_addr >= IO_BIT_LO) && (io_addr <= IO_BIT_HI);
    io_mod = io_rd_data;
    io_mod[io_bit] = (op == ALU_BSET);
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res_valid <= 1'b0;
      res_hi_valid <= 1'b0;
      res <= '0;
      res_hi <= '0;
      io_we <= 1'b0;
      io_refused <= 1'b0;
      io_wr_addr <= '0;
      io_wr_data <= '0;
      flags <= FLAGS_RST;
    end else begin
      res_valid <= 1'b0;
      res_hi_valid <= 1'b0;
      io_we <= 1'b0;
      io_refused <= 1'b0;
      if (st_q == ALU_WORD2) begin
        res <= res_lo_q;
        res_hi <= y;
        res_valid <= 1'b1;
        res_hi_valid <= 1'b1;
        flags[FLG_C] <= co;
        flags[FLG_Z] <= zr && zero_lo_q;
        flags[FLG_N] <= ng;
        flags[FLG_V] <= ov;
        flags[FLG_S] <= ng ^ ov;
      end else if (take && is_io(op)) begin
        io_we <= io_ok;
        io_refused <= !io_ok;
        io_wr_addr <= io_addr;
        io_wr_data <= io_mod;
      end else if (take && !is_word(op)) begin
        res <= y;
        res_valid <= 1'b1;
        flags[FLG_Z] <= zr;
        flags[FLG_N] <= ng;
        flags[FLG_V] <= ov;
        // logic ops move only zero, negative and overflow; sign stays too
        if (fn == 2'd0) begin
          flags[FLG_C] <= co;
          flags[FLG_H] <= hc;
          flags[FLG_S] <= ng ^ ov;
        end
      end
    end
  end

  a_byte_one_clk: assert property (@(posedge clk) disable iff (!rst_n_q)
    (take && !is_word(op) && !is_io(op)) |=> res_valid && !busy)
    else $error("byte op result not in one clock");
  sequence s_word_start;
    take && is_word(op);
  endsequence
  a_word_two_clk: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_word_start |=> busy && !res_valid ##1 res_valid && res_hi_valid)
    else $error("word op not two clocks");
  a_logic_keep_c: assert property (@(posedge clk) disable iff (!rst_n_q)
    (take && (op == ALU_AND || op == ALU_OR || op == ALU_ANDK)) |=>
      $stable(flags[FLG_C]) && $stable(flags[FLG_H]) && $stable(flags[FLG_S]))
    else $error("logic op touched carry");
  a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n_q)
    (res_valid && !res_hi_valid) |-> (flags[FLG_Z] == (res == '0)) && (flags[FLG_N] == res[DATA_W-1]))
    else $error("zero or negative flag wrong");
  a_io_range: assert property (@(posedge clk) disable iff (!rst_n_q)
    io_we |-> io_wr_addr <= IO_BIT_HI)
    else $error("io write out of range");
  a_io_rmw: assert property (@(posedge clk) disable iff (!rst_n_q)
    (take && is_io(op) && io_ok) |=> io_we && ((io_wr_data | (8'h01 << $past(io_bit)))
      == ($past(io_rd_data) | (8'h01 << $past(io_bit)))))
    else $error("io rmw lost other bits");
  a_sub_carry: assert property (@(posedge clk) disable iff (!rst_n_q)
    (take && op == ALU_SUBK) |=> res_valid && (flags[FLG_C] == ($past(imm) > $past(dst_val))))
    else $error("subtract borrow wrong");
  a_add_sum: assert property (@(posedge clk) disable iff (!rst_n_q)
    (take && op == ALU_ADD) |=> res == 8'($past(dst_val) + $past(src_val)))
    else $error("add result wrong");
endmodule : alu_exec

/* sim/alu_io_model.sv */
`timescale 1ns/100ps
// io register space behind the unit; plain always so the bench may preload it
module alu_io_model (
  // clock
  input wire logic clk,
  // access from the unit
  input wire logic [5:0] io_addr,
  output logic [7:0] io_rd_data,
  input wire logic io_we,
  input wire logic [5:0] io_wr_addr,
  input wire logic [7:0] io_wr_data,
  // bits that clear on a written one
  input wire logic [7:0] w1c_mask
);
  logic [7:0] regs_q [64];
  assign io_rd_data = regs_q[io_addr];
  always @(posedge clk) begin
    if (io_we) begin
      // a written zero leaves a flag alone, a written one clears it
      regs_q[io_wr_addr] <= (io_wr_data & ~w1c_mask) | (regs_q[io_wr_addr] & w1c_mask & ~io_wr_data);
    end
  end
endmodule : alu_io_model

/* sim/test_arith_logic_exec_unit.sv */
`timescale 1ns/100ps
module test_arith_logic_exec_unit;
  import alu_pkg::*;
  typedef struct {alu_op_e op; logic [7:0] a, b, hi, er, eh; logic [5:0] ef;} alu_row_s;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid = 1'b0;
  alu_op_e op = ALU_ADD;
  logic [7:0] dst_val = 8'h00, src_val = 8'h00, dst_hi_val = 8'h00, w1c = 8'h40;
  logic [5:0] io_addr = 6'h00;
  logic [2:0] io_bit = 3'h0;
  wire logic [7:0] io_rd_data, res, res_hi, io_wr_data;
  wire logic busy, res_valid, res_hi_valid, io_we, io_refused;
  wire logic [5:0] io_wr_addr;
  wire logic [5:0] flags;
  int n_fail = 0;
  int samples_checked = 0;
  alu_row_s rows [18] = '{
    '{ALU_ADD, 8'h0f, 8'h01, 8'h00, 8'h10, 8'h00, 6'h20}, '{ALU_ADC, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 6'h23},
    '{ALU_ADC, 8'h7f, 8'h00, 8'h00, 8'h80, 8'h00, 6'h2c}, '{ALU_SUB, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h00, 6'h20},
    '{ALU_SUB, 8'h80, 8'h01, 8'h00, 8'h7f, 8'h00, 6'h28}, '{ALU_SUBB, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 6'h25},
    '{ALU_SUBB, 8'h05, 8'h02, 8'h00, 8'h02, 8'h00, 6'h00}, '{ALU_SUBK, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 6'h02},
    '{ALU_SUBK, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 6'h25}, '{ALU_SUBBK, 8'h10, 8'h0e, 8'h00, 8'h01, 8'h00, 6'h20},
    '{ALU_SUBBK, 8'h01, 8'h02, 8'h00, 8'hff, 8'h00, 6'h25}, '{ALU_AND, 8'hf0, 8'h0f, 8'h00, 8'h00, 8'h00, 6'h23},
    '{ALU_ANDK, 8'hf0, 8'h80, 8'h00, 8'h80, 8'h00, 6'h25}, '{ALU_OR, 8'h40, 8'h01, 8'h00, 8'h41, 8'h00, 6'h21},
    '{ALU_WADD, 8'hff, 8'h01, 8'h00, 8'h00, 8'h01, 6'h20}, '{ALU_WADD, 8'hff, 8'h3f, 8'h7f, 8'h3e, 8'h80, 6'h2c},
    '{ALU_WSUB, 8'h00, 8'h01, 8'h00, 8'hff, 8'hff, 6'h35}, '{ALU_WSUB, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 6'h22}};
  always #4 clk = ~clk;
  alu_exec u_dut (.clk, .arst_n, .op_valid, .op, .dst_val, .src_val, .dst_hi_val, .imm(src_val), .io_addr,
    .io_bit, .io_rd_data, .io_w1c_mask(w1c), .busy, .res_valid, .res_hi_valid, .res, .res_hi, .io_we,
    .io_refused, .io_wr_addr, .io_wr_data, .flags);
  alu_io_model u_io (.clk, .io_addr, .io_rd_data, .io_we, .io_wr_addr, .io_wr_data, .w1c_mask(w1c));
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chkf(logic [5:0] e, logic [5:0] m, logic [5:0] g);
    samples_checked++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("mismatch flags expected %h seen %h", e & m, g & m);
    end
  endtask : chkf
  // drive just after an edge and hold until the taking edge; returns 1 ns after it
  task automatic issue(alu_op_e o, logic [7:0] a, logic [7:0] b, logic [7:0] h, logic [5:0] ad, logic [2:0] bt);
    @(posedge clk);
    op_valid <= 1'b1;
    op <= o;
    dst_val <= a;
    src_val <= b;
    dst_hi_val <= h;
    io_addr <= ad;
    io_bit <= bt;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask : issue
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end
    else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (1000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    int n;
    logic wd;
    // bench software keeps away from reserved io locations
    u_io.regs_q[6'h0b] = 8'h40;
    u_io.regs_q[6'h1c] = 8'h80;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chkf(6'h00, 6'h3f, flags);
    chk8("res_valid", 8'h00, {7'h00, res_valid});
    $display("reset test done");
    foreach (rows[i]) begin
      wd = rows[i].op inside {ALU_WADD, ALU_WSUB};
      issue(rows[i].op, rows[i].a, rows[i].b, rows[i].hi, 6'h00, 3'h0);
      chk8("busy", {7'h00, wd}, {7'h00, busy});
      n = 1;
      while (res_valid !== 1'b1 && n < 4) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk8("cycles", wd ? 8'(CYC_WORD) : 8'(CYC_BYTE), 8'(n));
      chk8("res", rows[i].er, res);
      chkf(rows[i].ef, wd ? 6'h3f : 6'h2f, flags);
      if (wd) begin
        chk8("res_hi", rows[i].eh, res_hi);
        chk8("res_hi_valid", 8'h01, {7'h00, res_hi_valid});
      end
      $display("row %0d done", i);
    end
    issue(ALU_BSET, 8'h00, 8'h00, 8'h00, 6'h0b, 3'h0);
    chk8("io_we", 8'h01, {7'h00, io_we});
    chk8("io_wr_data", 8'h41, io_wr_data);
    chk8("io_wr_addr", 8'h0b, {2'b00, io_wr_addr});
    @(posedge clk);
    #1;
    chk8("flag after write back", 8'h01, u_io.regs_q[6'h0b]);
    issue(ALU_BCLR, 8'h00, 8'h00, 8'h00, 6'h1c, 3'h7);
    chk8("io_wr_data", 8'h00, io_wr_data);
    issue(ALU_BSET, 8'h00, 8'h00, 8'h00, 6'h21, 3'h0);
    chk8("refused no write", 8'h02, {6'h00, io_refused, io_we});
    $display("io test done");
    // reset in mid run: all flags and io_wr_data clear to zero at once
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    chkf(6'h00, 6'h3f, flags);
    chk8("io_wr_data after reset", 8'h00, io_wr_data);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    issue(ALU_ADD, 8'h01, 8'h02, 8'h00, 6'h00, 3'h0);
    chk8("res after reset", 8'h03, res);
    chk8("res_valid after reset", 8'h01, {7'h00, res_valid});
    $display("mid reset test done");
    tally_and_finish();
  end
endmodule : test_arith_logic_exec_unit
